// ===== rtl/scs_regs.svh
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// ----------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------
`define SCS_OFF_CTRL 6'h00
`define SCS_OFF_CHARS 6'h04
`define SCS_OFF_TIMERS 6'h08
`define SCS_OFF_INIT 6'h0C
`define SCS_OFF_FMT_MASTER 6'h10
`define SCS_OFF_FMT_A 6'h14
`define SCS_OFF_PRE_A 6'h24
`define SCS_OFF_CMD 6'h34
`define SCS_OFF_STATUS 6'h38

// ----------------------------------------------------------------
// word indices and sizes
// ----------------------------------------------------------------
`define SCS_CFG_WORDS 13
`define SCS_IDX_CTRL 4'h0
`define SCS_IDX_TIMERS 4'h2
`define SCS_IDX_FMT_MASTER 4'h4
`define SCS_IDX_LAST 4'hD
`define SCS_RAM_WORDS 16

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SCS_CTRL_AUTO 0
`define SCS_CTRL_DTR_GATE 1
`define SCS_CTRL_CMD3 2
`define SCS_CTRL_B2B 3
`define SCS_INIT_RX_EN 4
`define SCS_FMT_DATA8 4
`define SCS_FMT_HS 7
`define SCS_CMD_SAVE 0
`define SCS_CMD_TEST 1

// ----------------------------------------------------------------
// factory values and limits
// ----------------------------------------------------------------
`define SCS_DEF_CTRL 32'h0000_0004
`define SCS_DEF_CHARS 32'h0000_021B
`define SCS_DEF_TIMERS 32'h01F4_03E8
`define SCS_DEF_INIT 32'h0000_0011
`define SCS_DEF_FMT 32'h0000_0014
`define SCS_DEF_PRE 32'h0000_0000
`define SCS_TIMER_MAX 16'hFDE8
`define SCS_NVM_SIG 32'h5A3C_0001
`define SCS_RAM_PAT 32'hA5A5_A5A5
`define SCS_STRAP_WAIT 2'h2

`endif

// ===== rtl/scs_pkg.sv
package scs_pkg;
`include "scs_regs.svh"

    typedef enum logic [5:0] {
        SCS_LOAD = 6'b000001,
        SCS_IDLE = 6'b000010,
        SCS_SAVE = 6'b000100,
        SCS_TRAM_WR = 6'b001000,
        SCS_TRAM_RD = 6'b010000,
        SCS_TNVM = 6'b100000
    } scs_state_t;

    typedef logic [31:0] scs_word_t;

    function automatic scs_word_t scs_default(input logic [3:0] idx);
        case (idx)
            4'h0: scs_default = `SCS_DEF_CTRL;
            4'h1: scs_default = `SCS_DEF_CHARS;
            4'h2: scs_default = `SCS_DEF_TIMERS;
            4'h3: scs_default = `SCS_DEF_INIT;
            4'h4, 4'h5, 4'h6, 4'h7, 4'h8: scs_default = `SCS_DEF_FMT;
            default: scs_default = `SCS_DEF_PRE;
        endcase
    endfunction : scs_default

endpackage : scs_pkg

// ===== rtl/scs_config_store.sv
`timescale 1ns/100ps
// Functional notes
// - configuration lives in external non-volatile memory and reloads at power-up
// - setup mode only if jumper fitted at power-up; later fitting ignored
// - with DTR gating set, commands accepted only while master DTR asserted
// - command length two or three characters; each character stored
// - port time and inactivity time held in milliseconds, 0 to 65000
// - manual mode: initial master transmit routing to any set of four slaves
// - manual mode: optionally one slave given the path to the master
// - auto mode ignores stored slave-to-master connection; transmit routing stays
// - per port baud, data bits, parity, handshake; slave preambles stored
// - self test of transceivers, RAM and NVM, errors reported to host
// - back-to-back pairing forces auto selection and three-character command
// - back-to-back pairing forces master port hardware handshaking
// - default command: three characters, 27, then 2, then 0
// - default port time 1000 ms, inactivity time 500 ms
// - default 9600 baud, 8 bits, no parity, no handshake, no preamble
// - default auto selection off, DTR not required
// - default slave A connected both ways with master
// - host reads whole configuration in setup mode; save commits changes permanently
// - auto mode prefixes new slave packets with 1 to 4 preamble characters
module scs_config_store
    import scs_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic setup_mode_jumper,
    input wire logic master_dtr,
    input wire logic cmd_request,
    output logic cmd_accept,
    output logic [3:0] nvm_addr,
    output logic nvm_write,
    output logic [31:0] nvm_wdata,
    input wire logic [31:0] nvm_rdata,
    input wire logic nvm_busy,
    input wire logic xcvr_fault,
    output logic setup_mode,
    output logic cfg_ready,
    output logic auto_select,
    output logic cmd_three_chars,
    output logic [7:0] first_command_character,
    output logic [7:0] second_command_character,
    output logic [7:0] third_command_character,
    output logic [15:0] port_time_ms,
    output logic [15:0] inactivity_ms,
    output logic [3:0] init_tx_mask,
    output logic init_rx_enable,
    output logic [1:0] init_rx_port,
    output logic [19:0] port_baud,
    output logic [4:0] port_eight_bits,
    output logic [9:0] port_parity,
    output logic [4:0] port_handshake,
    output logic [11:0] preamble_len,
    output logic [127:0] preamble_chars,
    output logic [3:0] preamble_enable
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    scs_word_t cfg_q [0:`SCS_CFG_WORDS-1];
    scs_word_t ram_q [0:`SCS_RAM_WORDS-1];
    scs_state_t state_q;
    logic jmp_s1_q, jmp_s2_q, dtr_s1_q, dtr_s2_q;
    logic [1:0] strap_cnt_q;
    logic setup_q;
    logic [3:0] idx_q;
    logic [3:0] rd_idx_q;
    logic rd_v_q;
    logic ack_q;
    logic dirty_q, st_done_q, err_uart_q, err_ram_q, err_nvm_q;
    logic [31:0] rdata_q;

    function automatic scs_word_t merge_be(input scs_word_t old_w, input scs_word_t new_w,
                                          input logic [3:0] be);
        for (int b = 0; b < 4; b++) begin
            merge_be[b*8 +: 8] = be[b] ? new_w[b*8 +: 8] : old_w[b*8 +: 8];
        end
    endfunction : merge_be

    function automatic logic [15:0] clamp_ms(input logic [15:0] v);
        clamp_ms = (v > `SCS_TIMER_MAX) ? `SCS_TIMER_MAX : v;
    endfunction : clamp_ms

    function automatic scs_word_t ram_pattern(input logic [3:0] i);
        ram_pattern = {8{i}} ^ `SCS_RAM_PAT;
    endfunction : ram_pattern

    // ----------------------------------------------------------------
    // pin synchronisers and power-up strap
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            jmp_s1_q <= 1'b0;
            jmp_s2_q <= 1'b0;
            dtr_s1_q <= 1'b0;
            dtr_s2_q <= 1'b0;
        end else begin
            jmp_s1_q <= setup_mode_jumper;
            jmp_s2_q <= jmp_s1_q;
            dtr_s1_q <= master_dtr;
            dtr_s2_q <= dtr_s1_q;
        end
    end

    wire strap_done = (strap_cnt_q == 2'h3);

    // captured once after release; the pin is never looked at again
    always_ff @(posedge clk) begin
        if (!nrst) begin
            strap_cnt_q <= 2'h0;
            setup_q <= 1'b0;
        end else begin
            if (!strap_done) strap_cnt_q <= strap_cnt_q + 2'h1;
            if (strap_cnt_q == `SCS_STRAP_WAIT) setup_q <= jmp_s2_q;
        end
    end

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire busy = (state_q != SCS_IDLE);
    wire req = avs_read | avs_write;
    wire [3:0] word = avs_address[5:2];
    wire cfg_hit = (word <= `SCS_IDX_LAST - 4'h1);
    wire is_cmd = (word == 4'(`SCS_OFF_CMD >> 2));
    wire is_status = (word == 4'(`SCS_OFF_STATUS >> 2));
    wire ack_d = req & ~ack_q & ~busy & strap_done;
    wire wr_fire = avs_write & ack_q;
    wire cfg_wr = wr_fire & setup_q & cfg_hit;
    wire cmd_wr = wr_fire & setup_q & is_cmd & avs_byteenable[0];
    wire save_go = cmd_wr & avs_writedata[`SCS_CMD_SAVE];
    wire test_go = cmd_wr & ~avs_writedata[`SCS_CMD_SAVE] & avs_writedata[`SCS_CMD_TEST];
    wire [31:0] status_w = {25'h0, err_nvm_q, err_ram_q, err_uart_q, st_done_q, dirty_q,
                            busy, setup_q};
    wire scs_word_t cfg_rd = cfg_hit ? cfg_q[word] : 32'h0;
    wire scs_word_t merged = merge_be(cfg_rd, avs_writedata, avs_byteenable);
    // timer fields saturate so the held range never leaves the legal span
    wire scs_word_t wr_word = (word == `SCS_IDX_TIMERS) ?
                              {clamp_ms(merged[31:16]), clamp_ms(merged[15:0])} : merged;
    wire [31:0] rd_word = is_status ? status_w : (setup_q & cfg_hit) ? cfg_rd : 32'h0;

    assign avs_waitrequest = req & ~ack_q;
    assign avs_readdata = rdata_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q <= ack_d;
            if (ack_d) rdata_q <= rd_word;
        end
    end

    // ----------------------------------------------------------------
    // sequencer: load, save, self test
    // ----------------------------------------------------------------
    wire [3:0] cfg_sel = idx_q - 4'h1;
    wire [3:0] ld_sel = rd_idx_q - 4'h1;
    wire sig_ok = (nvm_rdata == `SCS_NVM_SIG);
    wire ld_take = (state_q == SCS_LOAD) & rd_v_q & (rd_idx_q != 4'h0);
    wire issue_rd = ((state_q == SCS_LOAD) & (idx_q <= `SCS_IDX_LAST))
                    | ((state_q == SCS_TNVM) & ~rd_v_q);
    wire wr_step = (state_q == SCS_SAVE) & ~nvm_busy;
    wire ram_bad = (ram_q[idx_q] != ram_pattern(idx_q));

    assign nvm_addr = idx_q;
    assign nvm_write = wr_step;
    // the signature goes last so an interrupted first save never looks valid
    assign nvm_wdata = (idx_q == 4'h0) ? `SCS_NVM_SIG :
                       (cfg_sel <= `SCS_IDX_LAST - 4'h1) ? cfg_q[cfg_sel] : 32'h0;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_v_q <= 1'b0;
            rd_idx_q <= 4'h0;
        end else begin
            rd_v_q <= issue_rd;
            rd_idx_q <= idx_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= SCS_LOAD;
            idx_q <= 4'h0;
        end else begin
            case (state_q)
                SCS_LOAD: begin
                    if (idx_q <= `SCS_IDX_LAST) idx_q <= idx_q + 4'h1;
                    if (rd_v_q && rd_idx_q == 4'h0 && !sig_ok) state_q <= SCS_IDLE;
                    if (rd_v_q && rd_idx_q == `SCS_IDX_LAST) state_q <= SCS_IDLE;
                end
                SCS_IDLE: begin
                    if (save_go) begin
                        state_q <= SCS_SAVE;
                        idx_q <= 4'h1;
                    end else if (test_go) begin
                        state_q <= SCS_TRAM_WR;
                        idx_q <= 4'h0;
                    end
                end
                SCS_SAVE: begin
                    if (wr_step) begin
                        idx_q <= (idx_q == `SCS_IDX_LAST) ? 4'h0 : idx_q + 4'h1;
                        if (idx_q == 4'h0) state_q <= SCS_IDLE;
                    end
                end
                SCS_TRAM_WR: begin
                    idx_q <= idx_q + 4'h1;
                    if (idx_q == 4'hF) state_q <= SCS_TRAM_RD;
                end
                SCS_TRAM_RD: begin
                    idx_q <= idx_q + 4'h1;
                    if (idx_q == 4'hF) state_q <= SCS_TNVM;
                end
                SCS_TNVM: begin
                    if (rd_v_q) state_q <= SCS_IDLE;
                end
                default: begin
                    state_q <= SCS_IDLE;
                end
            endcase
        end
    end

    // working RAM under test: write a pattern, then read it back
    always_ff @(posedge clk) begin
        if (state_q == SCS_TRAM_WR) ram_q[idx_q] <= ram_pattern(idx_q);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_done_q <= 1'b0;
            err_uart_q <= 1'b0;
            err_ram_q <= 1'b0;
            err_nvm_q <= 1'b0;
        end else if (test_go) begin
            st_done_q <= 1'b0;
            err_uart_q <= 1'b0;
            err_ram_q <= 1'b0;
            err_nvm_q <= 1'b0;
        end else begin
            if (busy && state_q != SCS_LOAD && state_q != SCS_SAVE && xcvr_fault)
                err_uart_q <= 1'b1;
            if (state_q == SCS_TRAM_RD && ram_bad) err_ram_q <= 1'b1;
            if (state_q == SCS_TNVM && rd_v_q) begin
                err_nvm_q <= ~sig_ok;
                st_done_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration words
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < `SCS_CFG_WORDS; i++) begin
                cfg_q[i] <= scs_default(4'(i));
            end
        end else if (ld_take && ld_sel <= `SCS_IDX_LAST - 4'h1) begin
            cfg_q[ld_sel] <= nvm_rdata;
        end else if (cfg_wr) begin
            cfg_q[word] <= wr_word;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dirty_q <= 1'b0;
        end else if (cfg_wr) begin
            dirty_q <= 1'b1;
        end else if (wr_step && idx_q == 4'h0) begin
            dirty_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // outputs toward the switching logic
    // ----------------------------------------------------------------
    wire b2b = cfg_q[`SCS_IDX_CTRL][`SCS_CTRL_B2B];
    wire dtr_gate = cfg_q[`SCS_IDX_CTRL][`SCS_CTRL_DTR_GATE];

    assign setup_mode = setup_q;
    assign cfg_ready = strap_done & (state_q != SCS_LOAD);
    // commands only steer the switch in normal operation
    assign cmd_accept = cmd_request & ~setup_q & cfg_ready & (~dtr_gate | dtr_s2_q);
    assign auto_select = cfg_q[`SCS_IDX_CTRL][`SCS_CTRL_AUTO] | b2b;
    assign cmd_three_chars = cfg_q[`SCS_IDX_CTRL][`SCS_CTRL_CMD3] | b2b;
    assign first_command_character = cfg_q[1][7:0];
    assign second_command_character = cfg_q[1][15:8];
    assign third_command_character = cfg_q[1][23:16];
    assign port_time_ms = cfg_q[`SCS_IDX_TIMERS][15:0];
    assign inactivity_ms = cfg_q[`SCS_IDX_TIMERS][31:16];
    assign init_tx_mask = cfg_q[3][3:0];
    assign init_rx_enable = cfg_q[3][`SCS_INIT_RX_EN] & ~auto_select;
    assign init_rx_port = cfg_q[3][6:5];

    genvar p;
    generate
        for (p = 0; p < 5; p++) begin : g_port
            assign port_baud[p*4 +: 4] = cfg_q[4+p][3:0];
            assign port_eight_bits[p] = cfg_q[4+p][`SCS_FMT_DATA8];
            assign port_parity[p*2 +: 2] = cfg_q[4+p][6:5];
            assign port_handshake[p] = cfg_q[4+p][`SCS_FMT_HS] | ((p == 0) & b2b);
        end
        for (p = 0; p < 4; p++) begin : g_pre
            assign preamble_len[p*3 +: 3] = cfg_q[5+p][10:8];
            assign preamble_chars[p*32 +: 32] = cfg_q[9+p];
            assign preamble_enable[p] = auto_select & (cfg_q[5+p][10:8] != 3'h0);
        end
    endgenerate

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_SETUP_STICKY: assert property (@(posedge clk) disable iff (!nrst)
        strap_done |=> setup_q == $past(setup_q))
        else $error("setup mode changed after power-up");

    AST_DTR_GATE: assert property (@(posedge clk) disable iff (!nrst)
        (cmd_request && dtr_gate && !dtr_s2_q) |-> !cmd_accept)
        else $error("command accepted without DTR");

    AST_B2B_AUTO: assert property (@(posedge clk) disable iff (!nrst)
        b2b |-> (auto_select && cmd_three_chars))
        else $error("pairing without auto mode and three characters");

    AST_B2B_HS: assert property (@(posedge clk) disable iff (!nrst)
        b2b |-> port_handshake[0])
        else $error("pairing without master handshake");

    AST_AUTO_NO_RX: assert property (@(posedge clk) disable iff (!nrst)
        auto_select |-> !init_rx_enable)
        else $error("initial slave path in auto mode");

    AST_NORMAL_NO_CHANGE: assert property (@(posedge clk) disable iff (!nrst)
        (strap_done && !setup_q) |-> (!dirty_q && state_q inside {SCS_LOAD, SCS_IDLE}))
        else $error("configuration activity outside setup mode");

    AST_SAVE_START: assert property (@(posedge clk) disable iff (!nrst)
        save_go |=> (state_q == SCS_SAVE && idx_q == 4'h1 && dirty_q == $past(dirty_q)))
        else $error("save did not start");

    AST_SAVE_END: assert property (@(posedge clk) disable iff (!nrst)
        (wr_step && idx_q == 4'h0) |-> nvm_wdata == `SCS_NVM_SIG ##1
        (state_q == SCS_IDLE && !dirty_q))
        else $error("save did not end with signature");

    AST_TEST_END: assert property (@(posedge clk) disable iff (!nrst)
        test_go |=> !st_done_q ##34 st_done_q)
        else $error("self test did not finish in time");

    AST_PREAMBLE: assert property (@(posedge clk) disable iff (!nrst)
        preamble_enable[0] |-> (auto_select && preamble_len[2:0] != 3'h0))
        else $error("preamble outside auto mode");

    AST_TIMER_RANGE: assert property (@(posedge clk) disable iff (!nrst)
        (port_time_ms <= `SCS_TIMER_MAX) && (inactivity_ms <= `SCS_TIMER_MAX))
        else $error("timer beyond range");

endmodule : scs_config_store

// ===== verif/scs_nvm_model.sv
`timescale 1ns/100ps
`include "scs_regs.svh"
// ----------------------------------------------------------------
// non-volatile store behind the config block, sync read
// ----------------------------------------------------------------
module scs_nvm_model
    import scs_pkg::*;
(
    input wire logic clk,
    input wire logic slow,
    input wire logic [3:0] nvm_addr,
    input wire logic nvm_write,
    input wire logic [31:0] nvm_wdata,
    output logic [31:0] nvm_rdata,
    output logic nvm_busy
);
    scs_word_t mem [`SCS_RAM_WORDS];

    // erased cells read all ones, so a fresh part has no valid signature
    initial begin
        for (int i = 0; i < `SCS_RAM_WORDS; i++) begin
            mem[i] = 32'hFFFF_FFFF;
        end
        nvm_rdata = 32'h0000_0000;
        nvm_busy = 1'b0;
    end

    // slow mode keeps busy every other cycle to stall save writes
    always @(posedge clk) begin
        nvm_busy <= slow & ~nvm_busy;
        nvm_rdata <= mem[nvm_addr];
        if (nvm_write && !nvm_busy) begin
            mem[nvm_addr] <= nvm_wdata;
        end
    end
endmodule : scs_nvm_model

// ===== verif/tb.sv
`timescale 1ns/100ps
`include "scs_regs.svh"
module tb;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, nvm_wdata, nvm_rdata;
    logic [3:0] avs_byteenable = 4'hF, nvm_addr, init_tx_mask, preamble_enable;
    logic avs_waitrequest, setup_mode_jumper = 1'b1, master_dtr = 1'b0, cmd_request = 1'b0;
    logic cmd_accept, nvm_write, nvm_busy, xcvr_fault = 1'b0, slow = 1'b0;
    logic setup_mode, cfg_ready, auto_select, cmd_three_chars, init_rx_enable;
    logic [7:0] ch1, ch2, ch3;
    logic [15:0] port_time_ms, inactivity_ms;
    logic [1:0] init_rx_port;
    logic [19:0] port_baud;
    logic [4:0] port_eight_bits, port_handshake;
    logic [9:0] port_parity;
    logic [11:0] preamble_len;
    logic [127:0] preamble_chars;
    logic [31:0] rd;
    int num_errors = 0, checks = 0, cycles = 0;

    always #25 clk = ~clk;

    scs_config_store scs_config_store_inst (.clk(clk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .setup_mode_jumper(setup_mode_jumper), .master_dtr(master_dtr),
        .cmd_request(cmd_request), .cmd_accept(cmd_accept), .nvm_addr(nvm_addr),
        .nvm_write(nvm_write), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
        .nvm_busy(nvm_busy), .xcvr_fault(xcvr_fault), .setup_mode(setup_mode),
        .cfg_ready(cfg_ready), .auto_select(auto_select), .cmd_three_chars(cmd_three_chars),
        .first_command_character(ch1), .second_command_character(ch2),
        .third_command_character(ch3), .port_time_ms(port_time_ms),
        .inactivity_ms(inactivity_ms), .init_tx_mask(init_tx_mask),
        .init_rx_enable(init_rx_enable), .init_rx_port(init_rx_port), .port_baud(port_baud),
        .port_eight_bits(port_eight_bits), .port_parity(port_parity),
        .port_handshake(port_handshake), .preamble_len(preamble_len),
        .preamble_chars(preamble_chars), .preamble_enable(preamble_enable));

    scs_nvm_model scs_nvm_model_inst (.clk(clk), .slow(slow), .nvm_addr(nvm_addr),
        .nvm_write(nvm_write), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata),
        .nvm_busy(nvm_busy));

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // waitrequest and read data both sampled at the rising edge
    task automatic wait_ack;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
    endtask : wait_ack

    task automatic bus_wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
        // outputs show the new word only after the accepting edge
        @(posedge clk);
    endtask : bus_wr

    task automatic bus_rd(input logic [5:0] a);
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        wait_ack();
        avs_read <= 1'b0;
    endtask : bus_rd

    task automatic rd_chk(input string name, input logic [5:0] a, input logic [31:0] exp);
        bus_rd(a);
        chk(name, exp, rd);
    endtask : rd_chk

    task automatic boot(input logic jumper);
        nrst <= 1'b0;
        setup_mode_jumper <= jumper;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int n = 0; n < 200 && cfg_ready !== 1'b1; n++) @(posedge clk);
        chk("cfg_ready", 32'h1, {31'h0, cfg_ready});
    endtask : boot

    // poll status until the sequencer drops busy
    task automatic wait_idle;
        for (int n = 0; n < 100; n++) begin
            bus_rd(`SCS_OFF_STATUS);
            if (rd[1] === 1'b0) break;
        end
        chk("status_idle", 32'h0, {31'h0, rd[1]});
    endtask : wait_idle

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        boot(1'b1);
        chk("setup", 32'h1, {31'h0, setup_mode});
        chk("chars", 32'h0000_021B, {8'h00, ch3, ch2, ch1});
        chk("cmd3", 32'h1, {31'h0, cmd_three_chars});
        chk("timers", 32'h01F4_03E8, {inactivity_ms, port_time_ms});
        chk("fmt", 32'h44444, {12'h000, port_baud});
        chk("bits", 32'h1F, {27'h0, port_eight_bits});
        chk("par_hs", 32'h0, {17'h0, port_parity, port_handshake});
        chk("pre", 32'h0, {28'h0, preamble_enable});
        chk("auto", 32'h0, {31'h0, auto_select});
        chk("init", 32'h11, {25'h0, init_rx_port, init_rx_enable, init_tx_mask});
        rd_chk("rd_ctrl", `SCS_OFF_CTRL, `SCS_DEF_CTRL);
        rd_chk("rd_timers", `SCS_OFF_TIMERS, `SCS_DEF_TIMERS);
        rd_chk("rd_fmt_m", `SCS_OFF_FMT_MASTER, `SCS_DEF_FMT);
        rd_chk("rd_unmapped", 6'h3C, 32'h0);
        cmd_request <= 1'b1;
        master_dtr <= 1'b1;
        repeat (4) @(posedge clk);
        chk("accept_setup", 32'h0, {31'h0, cmd_accept});
        bus_wr(`SCS_OFF_TIMERS, 32'hFFFF_0000, 4'hF);
        rd_chk("clamp", `SCS_OFF_TIMERS, 32'hFDE8_0000);
        bus_wr(`SCS_OFF_CHARS, 32'h0000_3300, 4'h2);
        chk("chars_be", 32'h0000_331B, {8'h00, ch3, ch2, ch1});
        bus_wr(`SCS_OFF_CTRL, 32'h1, 4'hF);
        chk("auto_init", 32'h21, {26'h0, auto_select, cmd_three_chars, init_rx_enable,
            init_tx_mask[2:0]});
        bus_wr(`SCS_OFF_FMT_A, 32'h0000_0394, 4'hF);
        bus_wr(`SCS_OFF_PRE_A, 32'h4142_4344, 4'hF);
        chk("pre_a", 32'h0001_8101, {14'h0, preamble_len[2:0], 3'h0, port_handshake, 3'h0,
            preamble_enable});
        chk("pre_chars", 32'h4142_4344, preamble_chars[31:0]);
        bus_wr(`SCS_OFF_CTRL, 32'h8, 4'hF);
        chk("b2b", 32'h7, {29'h0, auto_select, cmd_three_chars, port_handshake[0]});
        bus_wr(`SCS_OFF_CTRL, 32'h6, 4'hF);
        bus_wr(`SCS_OFF_INIT, 32'h0000_005A, 4'hF);
        chk("init_man", 32'h5A, {25'h0, init_rx_port, init_rx_enable, init_tx_mask});
        slow <= 1'b1;
        bus_wr(`SCS_OFF_CMD, 32'h1, 4'h1);
        wait_idle();
        chk("dirty", 32'h0, {31'h0, rd[2]});
        chk("nvm_sig", `SCS_NVM_SIG, scs_nvm_model_inst.mem[0]);
        chk("nvm_ctrl", 32'h6, scs_nvm_model_inst.mem[1]);
        slow <= 1'b0;
        xcvr_fault <= 1'b1;
        bus_wr(`SCS_OFF_CMD, 32'h2, 4'h1);
        wait_idle();
        chk("selftest", 32'h19, {25'h0, rd[6:0]});
        xcvr_fault <= 1'b0;
        boot(1'b0);
        setup_mode_jumper <= 1'b1;
        repeat (6) @(posedge clk);
        chk("late_jumper", 32'h0, {31'h0, setup_mode});
        chk("kept_chars", 32'h0000_331B, {8'h00, ch3, ch2, ch1});
        chk("kept_timers", 32'hFDE8_0000, {inactivity_ms, port_time_ms});
        chk("kept_init", 32'h5A, {25'h0, init_rx_port, init_rx_enable, init_tx_mask});
        rd_chk("rd_locked", `SCS_OFF_CTRL, 32'h0);
        master_dtr <= 1'b0;
        repeat (4) @(posedge clk);
        chk("dtr_low", 32'h0, {31'h0, cmd_accept});
        master_dtr <= 1'b1;
        repeat (4) @(posedge clk);
        chk("dtr_high", 32'h1, {31'h0, cmd_accept});
        test_done();
    end
endmodule : tb
